/* File: bench/pio_pin_model.sv */
// Behavioural model of eight external pins of one port.
// Assumes an external driver never fights a pad that the block drives.
`timescale 1ns/1ps
module pio_pin_model (
    input wire logic clk,
    input wire pio_pkg::pio_byte_t pad_out,
    input wire pio_pkg::pio_byte_t pad_oe_n,
    input wire pio_pkg::pio_byte_t pullup_en,
    input wire pio_pkg::pio_byte_t ext_en,
    input wire pio_pkg::pio_byte_t ext_val,
    output pio_pkg::pio_byte_t pad_in
);
    import pio_pkg::*;
    pio_byte_t float_val = 8'h55;
    // A floating pin flips every cycle so it never passes for a level.
    always @(posedge clk) begin
        float_val <= ~float_val;
    end
    // Pad drive wins, then an outside driver, then the weak pull-up.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pad_in[i] = 1'b1;
            end else begin
                pad_in[i] = float_val[i];
            end
        end
    end
endmodule // pio_pin_model

/* File: bench/pio_regs_checker.sv */
// Port-level assertions for the two-port I/O register block.
// Assumes it is bound into pio_port_regs and sees only its ports.
`timescale 1ns/1ps
module pio_regs_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    input wire pio_pkg::pio_byte_t sfr_wdata,
    input wire pio_pkg::pio_byte_t sfr_rdata,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_wr,
    input wire logic sfr_bit_rd,
    input wire logic sfr_bit_rdata,
    input wire pio_pkg::pio_byte_t p0_pad_out,
    input wire pio_pkg::pio_byte_t p0_pad_oe_n,
    input wire pio_pkg::pio_byte_t p0_pullup_en,
    input wire pio_pkg::pio_byte_t p0_rx_en,
    input wire pio_pkg::pio_byte_t p0_xbar_od,
    input wire pio_pkg::pio_byte_t p0_pin_level,
    input wire pio_pkg::pio_byte_t p1_pad_out,
    input wire pio_pkg::pio_byte_t p1_pad_oe_n
);
    import pio_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // A port 0 latch write followed at once by a latch read.
    sequence s_p0_write;
        sfr_wr && sfr_addr == 8'h80 && !sfr_bit_wr;
    endsequence
    sequence s_rmw_read;
        sfr_rd && sfr_rmw && !sfr_wr && !sfr_bit_wr && sfr_addr == 8'h80;
    endsequence
    property p_rmw_latch;
        s_p0_write ##1 s_rmw_read |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_rmw_latch: assert property (p_rmw_latch)
        else $error("latch readback differs from written byte");
    property p_unmapped_rd;
        sfr_rd && !(sfr_addr inside {8'h80, 8'h90, 8'ha4, 8'hd4, 8'hf1,
            8'hf2}) |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd)
        else $error("unmapped byte read not zero");
    property p_bit_unmapped;
        sfr_bit_rd && !(sfr_bit_addr[7:3] inside {5'h10, 5'h12})
            |=> !sfr_bit_rdata;
    endproperty
    a_bit_unmapped: assert property (p_bit_unmapped)
        else $error("non-port bit read not zero");
    property p_rdata_holds;
        !sfr_rd |=> $stable(sfr_rdata);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read answer moved without a read");
    property p_analog_no_drive;
        (~p0_rx_en & ~p0_pad_oe_n) == 8'h00;
    endproperty
    a_analog_no_drive: assert property (p_analog_no_drive)
        else $error("analog pin is driven");
    property p_pullup_mode;
        p0_pullup_en == p0_rx_en;
    endproperty
    a_pullup_mode: assert property (p_pullup_mode)
        else $error("pull-up and receiver disagree on mode");
    property p_analog_level;
        ($past(~p0_rx_en) & ~p0_rx_en & p0_pin_level) == 8'h00;
    endproperty
    a_analog_level: assert property (p_analog_level)
        else $error("analog pin shows a high level");
    property p_twowire_od;
        ($past(p0_xbar_od) & p0_xbar_od & ~p0_pad_oe_n & p0_pad_out) == 0;
    endproperty
    a_twowire_od: assert property (p_twowire_od)
        else $error("two-wire pin driven high");
    property p_release_low;
        (p0_pad_oe_n & p0_pad_out) == 0 && (~p1_pad_oe_n & p1_pad_out) == 0;
    endproperty
    a_release_low: assert property (p_release_low)
        else $error("released or open-drain pin shows high drive");
endmodule // pio_regs_checker

bind pio_port_regs pio_regs_checker u_chk (
    .clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rmw, .sfr_wdata,
    .sfr_rdata, .sfr_bit_addr, .sfr_bit_wr, .sfr_bit_rd, .sfr_bit_rdata,
    .p0_pad_out, .p0_pad_oe_n, .p0_pullup_en, .p0_rx_en, .p0_xbar_od,
    .p0_pin_level, .p1_pad_out, .p1_pad_oe_n
);

/* File: bench/port_io_config_regs_tb_top.sv */
// Self-checking bench for the two-port I/O register block.
// Assumes the pin models stand on both ports; the bench plays crossbar.
`timescale 1ns/1ps
module port_io_config_regs_tb_top;
    import pio_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_bit_addr = 8'h00;
    logic sfr_wr = 0, sfr_rd = 0, sfr_rmw = 0;
    logic sfr_bit_wr = 0, sfr_bit_rd = 0, sfr_bit_wval = 0, sfr_bit_rdata;
    pio_byte_t sfr_wdata = 8'h00, sfr_rdata;
    pio_byte_t p0_in, p0_out, p0_oe_n, p0_pu, p0_rx, p0_skip, p0_lvl;
    pio_byte_t p1_in, p1_out, p1_oe_n, p1_pu, p1_rx, p1_lvl;
    pio_byte_t claim0 = 0, xout0 = 0, od0 = 0, claim1 = 0, xout1 = 0;
    pio_byte_t od1 = 0, ext_en0 = 0, ext_val0 = 0;
    int fail_count = 0, comparisons = 0, cycles = 0;
    logic [7:0] ra [6] = '{8'h80, 8'h90, 8'ha4, 8'hd4, 8'hf1, 8'hf2};
    logic [7:0] rv [6] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    pio_port_regs dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_rd(sfr_bit_rd), .sfr_bit_wval(sfr_bit_wval),
        .sfr_bit_rdata(sfr_bit_rdata), .p0_pad_in(p0_in),
        .p0_pad_out(p0_out), .p0_pad_oe_n(p0_oe_n), .p0_pullup_en(p0_pu),
        .p0_rx_en(p0_rx), .p1_pad_in(p1_in), .p1_pad_out(p1_out),
        .p1_pad_oe_n(p1_oe_n), .p1_pullup_en(p1_pu), .p1_rx_en(p1_rx),
        .p0_xbar_claim(claim0), .p0_xbar_out(xout0), .p0_xbar_od(od0),
        .p1_xbar_claim(claim1), .p1_xbar_out(xout1), .p1_xbar_od(od1),
        .p0_xbar_skip(p0_skip), .p0_pin_level(p0_lvl),
        .p1_pin_level(p1_lvl));
    pio_pin_model pins0 (.clk(clk), .pad_out(p0_out), .pad_oe_n(p0_oe_n),
        .pullup_en(p0_pu), .ext_en(ext_en0), .ext_val(ext_val0),
        .pad_in(p0_in));
    pio_pin_model pins1 (.clk(clk), .pad_out(p1_out), .pad_oe_n(p1_oe_n),
        .pullup_en(p1_pu), .ext_en(8'h00), .ext_val(8'h00), .pad_in(p1_in));
    // Free-running 125 MHz clock.
    initial begin
        forever #4 clk = ~clk;
    end
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    // Compares a seen value with an expected one and counts both outcomes.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    // Byte write: strobe raised on one falling edge, dropped on the next.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    // Byte read with a check of the answer.
    task automatic rdc(input logic [7:0] a, input logic m,
        input logic [7:0] e);
        @(negedge clk);
        sfr_addr = a;
        sfr_rmw = m;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        sfr_rmw = 1'b0;
        chk(sfr_rdata, e);
    endtask
    // Bit write and checked bit read.
    task automatic bwr(input logic [7:0] a, input logic v);
        @(negedge clk);
        sfr_bit_addr = a;
        sfr_bit_wval = v;
        sfr_bit_wr = 1'b1;
        @(negedge clk);
        sfr_bit_wr = 1'b0;
    endtask
    task automatic brdc(input logic [7:0] a, input logic m, input logic e);
        @(negedge clk);
        sfr_bit_addr = a;
        sfr_rmw = m;
        sfr_bit_rd = 1'b1;
        @(negedge clk);
        sfr_bit_rd = 1'b0;
        sfr_rmw = 1'b0;
        chk({7'h00, sfr_bit_rdata}, {7'h00, e});
    endtask
    // Lets pad outputs and the input synchronisers settle.
    task automatic settle;
        repeat (5) @(negedge clk);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence of scenarios.
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) rdc(ra[i], 1'b1, rv[i]);
        chk(p0_oe_n, 8'hff);
        for (int i = 0; i < 6; i++) wr(ra[i], 8'h96);
        for (int i = 0; i < 6; i++) rdc(ra[i], 1'b1, 8'h96);
        chk(p0_skip, 8'h96);
        wr(8'h81, 8'h5a);
        rdc(8'h81, 1'b0, 8'h00);
        wr(8'hf1, 8'hff);
        wr(8'hf2, 8'hff);
        wr(8'ha4, 8'h00);
        wr(8'hd4, 8'h00);
        // Latch write and latch read on consecutive edges.
        @(negedge clk);
        sfr_addr = 8'h80;
        sfr_wdata = 8'h5a;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_rmw = 1'b1;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        sfr_rmw = 1'b0;
        chk(sfr_rdata, 8'h5a);
        ext_en0 = 8'h5a;
        settle();
        chk(p0_oe_n, 8'h5a);
        chk(p0_out, 8'h00);
        rdc(8'h80, 1'b0, 8'h00);
        rdc(8'h80, 1'b1, 8'h5a);
        ext_en0 = 8'h00;
        wr(8'ha4, 8'hff);
        settle();
        chk(p0_oe_n, 8'h00);
        chk(p0_out, 8'h5a);
        wr(8'h80, 8'hff);
        wr(8'hf1, 8'h0f);
        settle();
        chk(p0_oe_n, 8'hf0);
        chk(p0_pu, 8'h0f);
        chk(p0_rx, 8'h0f);
        chk(p0_out, 8'h0f);
        chk(p0_lvl, 8'h0f);
        rdc(8'h80, 1'b0, 8'h0f);
        wr(8'hf1, 8'hff);
        wr(8'h80, 8'h00);
        wr(8'hd4, 8'h0f);
        claim0 = 8'hff;
        xout0 = 8'haa;
        settle();
        chk(p0_out, 8'ha0);
        chk(p0_oe_n, 8'h00);
        od0 = 8'h30;
        settle();
        chk(p0_oe_n, 8'h20);
        chk(p0_out, 8'h80);
        rdc(8'h80, 1'b0, 8'ha0);
        // Restore an all-ones port 1 latch so the bit write clears a one.
        wr(8'h90, 8'hff);
        bwr(8'h93, 1'b0);
        settle();
        chk(p1_oe_n, 8'hf7);
        chk(p1_out, 8'h00);
        chk(p1_lvl, 8'hf7);
        brdc(8'h93, 1'b1, 1'b0);
        brdc(8'h94, 1'b0, 1'b1);
        brdc(8'ha1, 1'b0, 1'b0);
        wr(8'hf2, 8'h00);
        settle();
        chk(p1_rx, 8'h00);
        chk(p1_pu, 8'h00);
        rdc(8'h90, 1'b0, 8'h00);
        stop_test();
    end
endmodule // port_io_config_regs_tb_top

/* File: design/pio_defines.svh */
// Constants for the two-port I/O data and configuration block.
// Assumes an 8-bit special function register bus from the core.
// What this block does
// - Data write loads each pin's output latch.
// - Normal data read returns sensed pin levels.
// - Bit and byte access, visible on every page.
// - Input config bit: 0 analog, 1 digital.
// - Analog pin: pull-up, driver, receiver off.
// - Output drive bit: 0 open-drain, 1 push-pull.
// - Output drive bit ignored on analog pins.
// - Skip bit 1 makes crossbar pass pin.
// - Read-modify-write reads latch, not pin.
// - Data read shows pin even when crossbar-owned.
// - Two-wire bus pins always open-drain.
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// Byte addresses of the registers on the register bus.
`define PIO_ADDR_P0_DATA 8'h80
`define PIO_ADDR_P1_DATA 8'h90
`define PIO_ADDR_P0_DRIVE 8'ha4
`define PIO_ADDR_P0_SKIP 8'hd4
`define PIO_ADDR_P0_INCFG 8'hf1
`define PIO_ADDR_P1_INCFG 8'hf2

// Reset values of the registers.
`define PIO_RST_DATA 8'hff
`define PIO_RST_DRIVE 8'h00
`define PIO_RST_SKIP 8'h00
`define PIO_RST_INCFG 8'hff

// Value returned for an address this block does not own.
`define PIO_RD_UNMAPPED 8'h00

// Pad control, synchroniser and pin level values while reset is held.
`define PIO_RST_PAD_OUT 8'h00
`define PIO_RST_PAD_OE_N 8'hff
`define PIO_RST_PULLUP 8'hff
`define PIO_RST_RX_EN 8'hff
`define PIO_RST_SYNC 8'h00
`define PIO_RST_LEVEL 8'h00

// Bit address layout: high five bits pick the byte, low three the bit.
`define PIO_BIT_IDX_MSB 2
`define PIO_BIT_BYTE_LSB 3
`define PIO_BIT_IDX_ZERO 3'h0

// Port 1 has no drive or skip register in this block.
`define PIO_P1_DRIVE_FIXED 8'h00
`define PIO_P1_SKIP_FIXED 8'h00

`endif

/* File: design/pio_pin_cell.sv */
// Drive and receive decision for one port pin, purely combinational.
// Assumes the parent registers every output before it reaches a pad.
`timescale 1ns/1ps
module pio_pin_cell (
    input wire logic latch,
    input wire logic digital,
    input wire logic push_pull,
    input wire logic od_force,
    input wire logic claim,
    input wire logic skip,
    input wire logic xbar_val,
    output logic drv_val,
    output logic drv_oe_n,
    output logic pullup_en,
    output logic rx_en
);
    logic src;
    logic pp;

    // The crossbar value replaces the latch only on an unskipped claim.
    assign src = (claim && !skip) ? xbar_val : latch;

    // Two-wire bus pins never drive high, whatever the drive bit says.
    assign pp = push_pull && !od_force;

    // Analog mode turns everything off; the drive bit is then unused.
    always_comb begin
        drv_val = 1'b0;
        drv_oe_n = 1'b1;
        pullup_en = 1'b0;
        rx_en = 1'b0;
        if (digital) begin
            pullup_en = 1'b1;
            rx_en = 1'b1;
            if (pp) begin
                drv_val = src;
                drv_oe_n = 1'b0;
            end else begin
                drv_val = 1'b0;
                drv_oe_n = src;
            end
        end
    end

endmodule // pio_pin_cell

/* File: design/pio_pkg.sv */
// Types shared by the two-port I/O block.
// Assumes pio_defines.svh is on the include path.
package pio_pkg;

    // One port's worth of pins or register bits.
    typedef logic [7:0] pio_byte_t;

    // Register selected by a byte or bit address.
    typedef enum logic [2:0] {
        PIO_SEL_NONE,
        PIO_SEL_P0_DATA,
        PIO_SEL_P1_DATA,
        PIO_SEL_P0_DRIVE,
        PIO_SEL_P0_SKIP,
        PIO_SEL_P0_INCFG,
        PIO_SEL_P1_INCFG
    } pio_sel_t;

endpackage

/* File: design/pio_port_regs.sv */
// Register file and pad control for port 0 and port 1.
// Assumes the core's register bus is synchronous to clk and that pad
// inputs are asynchronous; crossbar signals are on clk.
`timescale 1ns/1ps
`include "pio_defines.svh"
module pio_port_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    input wire pio_pkg::pio_byte_t sfr_wdata,
    output pio_pkg::pio_byte_t sfr_rdata,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_wr,
    input wire logic sfr_bit_rd,
    input wire logic sfr_bit_wval,
    output logic sfr_bit_rdata,
    input wire pio_pkg::pio_byte_t p0_pad_in,
    output pio_pkg::pio_byte_t p0_pad_out,
    output pio_pkg::pio_byte_t p0_pad_oe_n,
    output pio_pkg::pio_byte_t p0_pullup_en,
    output pio_pkg::pio_byte_t p0_rx_en,
    input wire pio_pkg::pio_byte_t p1_pad_in,
    output pio_pkg::pio_byte_t p1_pad_out,
    output pio_pkg::pio_byte_t p1_pad_oe_n,
    output pio_pkg::pio_byte_t p1_pullup_en,
    output pio_pkg::pio_byte_t p1_rx_en,
    input wire pio_pkg::pio_byte_t p0_xbar_claim,
    input wire pio_pkg::pio_byte_t p0_xbar_out,
    input wire pio_pkg::pio_byte_t p0_xbar_od,
    input wire pio_pkg::pio_byte_t p1_xbar_claim,
    input wire pio_pkg::pio_byte_t p1_xbar_out,
    input wire pio_pkg::pio_byte_t p1_xbar_od,
    output pio_pkg::pio_byte_t p0_xbar_skip,
    output pio_pkg::pio_byte_t p0_pin_level,
    output pio_pkg::pio_byte_t p1_pin_level
);
    import pio_pkg::*;

    // Byte address decode, shared by the write and read paths.
    // No page input exists, so every register is seen on all pages.
    function automatic pio_sel_t byte_sel(input logic [7:0] a);
        pio_sel_t s;
        s = PIO_SEL_NONE;
        unique case (a)
            `PIO_ADDR_P0_DATA: s = PIO_SEL_P0_DATA;
            `PIO_ADDR_P1_DATA: s = PIO_SEL_P1_DATA;
            `PIO_ADDR_P0_DRIVE: s = PIO_SEL_P0_DRIVE;
            `PIO_ADDR_P0_SKIP: s = PIO_SEL_P0_SKIP;
            `PIO_ADDR_P0_INCFG: s = PIO_SEL_P0_INCFG;
            `PIO_ADDR_P1_INCFG: s = PIO_SEL_P1_INCFG;
            default: s = PIO_SEL_NONE;
        endcase
        return s;
    endfunction

    // Bit address decode: only the two data registers are bit addressed.
    function automatic pio_sel_t bit_sel(input logic [7:0] a);
        pio_sel_t s;
        logic [7:0] base;
        base = {a[7:`PIO_BIT_BYTE_LSB], `PIO_BIT_IDX_ZERO};
        s = PIO_SEL_NONE;
        if (base == `PIO_ADDR_P0_DATA) begin
            s = PIO_SEL_P0_DATA;
        end else if (base == `PIO_ADDR_P1_DATA) begin
            s = PIO_SEL_P1_DATA;
        end
        return s;
    endfunction

    pio_sel_t wr_sel;
    pio_sel_t rd_sel;
    pio_sel_t bwr_sel;
    pio_sel_t brd_sel;
    logic [2:0] bit_idx;

    // Configuration and latch registers.
    pio_byte_t p0_latch_ff;
    pio_byte_t p1_latch_ff;
    pio_byte_t p0_drive_ff;
    pio_byte_t p0_skip_ff;
    pio_byte_t p0_incfg_ff;
    pio_byte_t p1_incfg_ff;
    pio_byte_t nxt_p0_latch;
    pio_byte_t nxt_p1_latch;
    pio_byte_t nxt_p0_drive;
    pio_byte_t nxt_p0_skip;
    pio_byte_t nxt_p0_incfg;
    pio_byte_t nxt_p1_incfg;

    // Pad input synchronisers.
    pio_byte_t p0_sync1_ff;
    pio_byte_t p0_sync2_ff;
    pio_byte_t p1_sync1_ff;
    pio_byte_t p1_sync2_ff;

    // Levels seen through the digital receivers.
    pio_byte_t p0_level;
    pio_byte_t p1_level;

    // Read return registers.
    pio_byte_t rdata_ff;
    pio_byte_t nxt_rdata;
    logic bit_rdata_ff;
    logic nxt_bit_rdata;

    // Pad control and pin level registers for all sixteen pins.
    logic [15:0] pad_out_ff;
    logic [15:0] pad_oe_n_ff;
    logic [15:0] pullup_ff;
    logic [15:0] rx_en_ff;
    logic [15:0] level_ff;
    logic [15:0] nxt_pad_out;
    logic [15:0] nxt_pad_oe_n;
    logic [15:0] nxt_pullup;
    logic [15:0] nxt_rx_en;
    logic [15:0] nxt_level;

    // Per-pin inputs to the cells, port 1 in the upper byte.
    logic [15:0] all_latch;
    logic [15:0] all_incfg;
    logic [15:0] all_drive;
    logic [15:0] all_skip;
    logic [15:0] all_claim;
    logic [15:0] all_xout;
    logic [15:0] all_od;

    // Address decode of the current bus cycle.
    assign wr_sel = byte_sel(sfr_addr);
    assign rd_sel = byte_sel(sfr_addr);
    assign bwr_sel = bit_sel(sfr_bit_addr);
    assign brd_sel = bit_sel(sfr_bit_addr);
    assign bit_idx = sfr_bit_addr[`PIO_BIT_IDX_MSB:0];

    // A disabled receiver reads low, so analog pins show 0.
    assign p0_level = p0_sync2_ff & p0_incfg_ff;
    assign p1_level = p1_sync2_ff & p1_incfg_ff;

    // Next register contents: a byte write lands first, then any bit
    // write to the same register overrides its one bit.
    always_comb begin
        nxt_p0_latch = p0_latch_ff;
        nxt_p1_latch = p1_latch_ff;
        nxt_p0_drive = p0_drive_ff;
        nxt_p0_skip = p0_skip_ff;
        nxt_p0_incfg = p0_incfg_ff;
        nxt_p1_incfg = p1_incfg_ff;
        if (sfr_wr) begin
            unique case (wr_sel)
                PIO_SEL_P0_DATA: nxt_p0_latch = sfr_wdata;
                PIO_SEL_P1_DATA: nxt_p1_latch = sfr_wdata;
                PIO_SEL_P0_DRIVE: nxt_p0_drive = sfr_wdata;
                PIO_SEL_P0_SKIP: nxt_p0_skip = sfr_wdata;
                PIO_SEL_P0_INCFG: nxt_p0_incfg = sfr_wdata;
                PIO_SEL_P1_INCFG: nxt_p1_incfg = sfr_wdata;
                PIO_SEL_NONE: ;
            endcase
        end
        if (sfr_bit_wr) begin
            if (bwr_sel == PIO_SEL_P0_DATA) begin
                nxt_p0_latch[bit_idx] = sfr_bit_wval;
            end else if (bwr_sel == PIO_SEL_P1_DATA) begin
                nxt_p1_latch[bit_idx] = sfr_bit_wval;
            end
        end
    end

    // Register the latch and configuration state.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p0_latch_ff <= `PIO_RST_DATA;
            p1_latch_ff <= `PIO_RST_DATA;
            p0_drive_ff <= `PIO_RST_DRIVE;
            p0_skip_ff <= `PIO_RST_SKIP;
            p0_incfg_ff <= `PIO_RST_INCFG;
            p1_incfg_ff <= `PIO_RST_INCFG;
        end else begin
            p0_latch_ff <= nxt_p0_latch;
            p1_latch_ff <= nxt_p1_latch;
            p0_drive_ff <= nxt_p0_drive;
            p0_skip_ff <= nxt_p0_skip;
            p0_incfg_ff <= nxt_p0_incfg;
            p1_incfg_ff <= nxt_p1_incfg;
        end
    end

    // Two flip-flops per pad bring the pin levels onto clk.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p0_sync1_ff <= `PIO_RST_SYNC;
            p0_sync2_ff <= `PIO_RST_SYNC;
            p1_sync1_ff <= `PIO_RST_SYNC;
            p1_sync2_ff <= `PIO_RST_SYNC;
        end else begin
            p0_sync1_ff <= p0_pad_in;
            p0_sync2_ff <= p0_sync1_ff;
            p1_sync1_ff <= p1_pad_in;
            p1_sync2_ff <= p1_sync1_ff;
        end
    end

    // Byte and bit reads. A plain read shows the pin, whoever drives
    // it; a read that is part of read-modify-write shows the latch so
    // that a pin held low outside does not clear its latch bit.
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_bit_rdata = bit_rdata_ff;
        if (sfr_rd) begin
            unique case (rd_sel)
                PIO_SEL_P0_DATA: begin
                    nxt_rdata = sfr_rmw ? p0_latch_ff : p0_level;
                end
                PIO_SEL_P1_DATA: begin
                    nxt_rdata = sfr_rmw ? p1_latch_ff : p1_level;
                end
                PIO_SEL_P0_DRIVE: nxt_rdata = p0_drive_ff;
                PIO_SEL_P0_SKIP: nxt_rdata = p0_skip_ff;
                PIO_SEL_P0_INCFG: nxt_rdata = p0_incfg_ff;
                PIO_SEL_P1_INCFG: nxt_rdata = p1_incfg_ff;
                PIO_SEL_NONE: nxt_rdata = `PIO_RD_UNMAPPED;
            endcase
        end
        if (sfr_bit_rd) begin
            if (brd_sel == PIO_SEL_P0_DATA) begin
                nxt_bit_rdata = sfr_rmw ? p0_latch_ff[bit_idx]
                                        : p0_level[bit_idx];
            end else if (brd_sel == PIO_SEL_P1_DATA) begin
                nxt_bit_rdata = sfr_rmw ? p1_latch_ff[bit_idx]
                                        : p1_level[bit_idx];
            end else begin
                nxt_bit_rdata = 1'b0;
            end
        end
    end

    // Register the read answers; they hold until the next read.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= `PIO_RD_UNMAPPED;
            bit_rdata_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            bit_rdata_ff <= nxt_bit_rdata;
        end
    end

    // Gather both ports into sixteen lanes; port 1 has a fixed
    // open-drain drive and is never skipped.
    assign all_latch = {p1_latch_ff, p0_latch_ff};
    assign all_incfg = {p1_incfg_ff, p0_incfg_ff};
    assign all_drive = {`PIO_P1_DRIVE_FIXED, p0_drive_ff};
    assign all_skip = {`PIO_P1_SKIP_FIXED, p0_skip_ff};
    assign all_claim = {p1_xbar_claim, p0_xbar_claim};
    assign all_xout = {p1_xbar_out, p0_xbar_out};
    assign all_od = {p1_xbar_od, p0_xbar_od};
    assign nxt_level = {p1_level, p0_level};

    // One cell per pin decides drive, release, pull-up and receiver.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_pin
            pio_pin_cell u_cell (
                .latch(all_latch[gi]),
                .digital(all_incfg[gi]),
                .push_pull(all_drive[gi]),
                .od_force(all_od[gi]),
                .claim(all_claim[gi]),
                .skip(all_skip[gi]),
                .xbar_val(all_xout[gi]),
                .drv_val(nxt_pad_out[gi]),
                .drv_oe_n(nxt_pad_oe_n[gi]),
                .pullup_en(nxt_pullup[gi]),
                .rx_en(nxt_rx_en[gi])
            );
        end
    endgenerate

    // Register every pad control so the pads see clean edges.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_out_ff <= {`PIO_RST_PAD_OUT, `PIO_RST_PAD_OUT};
            pad_oe_n_ff <= {`PIO_RST_PAD_OE_N, `PIO_RST_PAD_OE_N};
            pullup_ff <= {`PIO_RST_PULLUP, `PIO_RST_PULLUP};
            rx_en_ff <= {`PIO_RST_RX_EN, `PIO_RST_RX_EN};
            level_ff <= {`PIO_RST_LEVEL, `PIO_RST_LEVEL};
        end else begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_n_ff <= nxt_pad_oe_n;
            pullup_ff <= nxt_pullup;
            rx_en_ff <= nxt_rx_en;
            level_ff <= nxt_level;
        end
    end

    // Outputs come straight from the registers above.
    assign sfr_rdata = rdata_ff;
    assign sfr_bit_rdata = bit_rdata_ff;
    assign p0_pad_out = pad_out_ff[7:0];
    assign p1_pad_out = pad_out_ff[15:8];
    assign p0_pad_oe_n = pad_oe_n_ff[7:0];
    assign p1_pad_oe_n = pad_oe_n_ff[15:8];
    assign p0_pullup_en = pullup_ff[7:0];
    assign p1_pullup_en = pullup_ff[15:8];
    assign p0_rx_en = rx_en_ff[7:0];
    assign p1_rx_en = rx_en_ff[15:8];
    assign p0_xbar_skip = p0_skip_ff;
    assign p0_pin_level = level_ff[7:0];
    assign p1_pin_level = level_ff[15:8];

endmodule // pio_port_regs
